// *** host_control_port.sv ***
// What this block does
// R1 - Hardware mode reads three template pins as code, first pin most significant.
// R2 - Serial output launches on falling shift edges if select high, else rising.
// R3 - Serial input is always sampled on rising shift-clock edges.
// R4 - Multiplexed strobe mode latches address bits 4:0 on address-latch falling edge.
// R5 - Multiplexed address latch ignores bus lines 7:5.
// R6 - Host holds address-latch input high in separate-bus mode.
// R7 - Multiplexed data-strobe mode latches address on address strobe falling; else held high.
// R8 - Strobe style: host drives read strobe low to read.
// R9 - Data-strobe style: direction low means write, high means read.
// R10 - Strobe style: data bus captured on rising edge of active-low write strobe.
// R11 - Data-strobe style: write data captured on data strobe rising edge.
// R12 - Data-strobe style read: device drives bus until the data strobe rises.
// R13 - Separate-bus data-strobe mode latches five address lines on data strobe falling.
// R14 - Mode pins pick hardware, serial or one of the parallel port styles.
// R15 - Host pulls chip select low per access and holds it until done.
// R16 - Five-bit address spans 32 locations; unused read zero, ignore writes.
`timescale 1ns/1ns
module host_control_port (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    input  wire logic        mode_sel_hi,
    input  wire logic        mode_sel_mid,
    input  wire logic        mode_sel_1,
    input  wire logic        mode_sel_0,
    input  wire logic        chip_sel_n,
    input  wire logic        template_sel_msb,
    input  wire logic        template_sel_mid,
    input  wire logic        template_sel_lsb,
    input  wire logic        shift_clk,
    input  wire logic        out_edge_select,
    input  wire logic [4:0]  addr_pins,
    input  wire logic [7:0]  bus_in,
    output logic      [7:0]  bus_out,
    output logic             bus_oe,
    output logic             serial_out,
    output logic             serial_out_oe,
    output logic      [2:0]  template_code
);

    // ********************************************************
    // Register array and its shared read decode
    // ********************************************************
    logic [7:0] regs_q [hcp_pkg::REG_LOCS];

    function automatic logic loc_used(input logic [4:0] a);
        loc_used = (a <= hcp_pkg::LAST_USED);                           // [R16]
    endfunction

    function automatic logic [7:0] reg_read(input logic [4:0] a);
        reg_read = loc_used(a) ? regs_q[a] : 8'h00;                     // [R16]
    endfunction

    // ********************************************************
    // Pin synchronisers
    // ********************************************************
    logic [hcp_pkg::PIN_W-1:0] pins_s;
    logic [3:0]                stb_prev_q;

    hcp_sync #(.WIDTH(hcp_pkg::PIN_W), .RST_VAL(hcp_pkg::PIN_RESET)) u_pin_sync (
        .clk   (hclk),
        .rst_n (hresetn),
        .d     ({mode_sel_hi, mode_sel_mid, mode_sel_1, mode_sel_0, chip_sel_n,
                 template_sel_msb, template_sel_mid, template_sel_lsb, addr_pins, bus_in}),
        .q     (pins_s)
    );

    wire        mode_hi_s  = pins_s[20];
    wire        mode_mid_s = pins_s[19];
    wire        mux_s      = pins_s[18];
    wire        strobe_s   = pins_s[17];
    wire        cs_s_n     = pins_s[16];
    wire [2:0]  tmpl_s     = pins_s[15:13];
    wire [4:0]  addr_s     = pins_s[12:8];
    wire [7:0]  bus_s      = pins_s[7:0];

    // Shared pins under their parallel roles
    wire        addr_strobe_n  = tmpl_s[2];     // Also address latch enable
    wire        rw_sel         = tmpl_s[1];     // Also read strobe, active low
    wire        data_strobe_n  = tmpl_s[0];     // Also write strobe, active low

    // Edge detect on second-stage copies only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stb_prev_q <= hcp_pkg::STB_RESET;
        end else begin
            stb_prev_q <= {cs_s_n, tmpl_s};
        end
    end

    wire as_fall  = stb_prev_q[2] & ~addr_strobe_n;
    wire rd_fall  = stb_prev_q[1] & ~rw_sel;
    wire rd_rise  = ~stb_prev_q[1] & rw_sel;
    wire ds_fall  = stb_prev_q[0] & ~data_strobe_n;
    wire ds_rise  = ~stb_prev_q[0] & data_strobe_n;
    wire cs_on    = ~cs_s_n;

    // ********************************************************
    // Port selection
    // ********************************************************
    wire [2:0] mode_code = {mode_hi_s, mux_s, strobe_s};
    wire       par_ok    = ~mode_mid_s & ((mode_code == hcp_pkg::MODE_NM_DS) |
                                          (mode_code == hcp_pkg::MODE_M_DS)  |
                                          (mode_code == hcp_pkg::MODE_NM_STB) |
                                          (mode_code == hcp_pkg::MODE_M_STB));     // [R14]
    wire       hw_mode   = ~mode_hi_s & ~mode_mid_s;                               // [R14]

    hcp_pkg::hcp_port_t port_sel;
    assign port_sel = mode_mid_s ? hcp_pkg::PORT_SERIAL :
                      par_ok     ? hcp_pkg::PORT_PAR    : hcp_pkg::PORT_HW;        // [R14]

    wire par_mode   = (port_sel == hcp_pkg::PORT_PAR);
    wire stb_style  = strobe_s;
    wire nm_ds_mode = par_mode & ~mux_s & ~stb_style;

    // Template code is only refreshed in hardware mode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            template_code <= 3'h0;
        end else if (hw_mode) begin
            template_code <= tmpl_s;                                    // [R1]
        end
    end

    // ********************************************************
    // Bus slave
    // ********************************************************
    logic        dp_valid_q;
    logic        dp_write_q;
    logic [7:0]  dp_addr_q;
    logic [31:0] ctrl_q;

    wire        ahb_take  = hsel & hready & (htrans == hcp_pkg::HTRANS_NSEQ);
    wire        dp_is_reg = (dp_addr_q <= hcp_pkg::OFS_REG_LAST);
    wire [4:0]  dp_idx    = dp_addr_q[6:2];
    wire        ahb_wr    = dp_valid_q & dp_write_q;
    wire        pin_en    = ctrl_q[hcp_pkg::CTRL_PIN_EN];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid_q <= 1'b0;
            dp_write_q <= 1'b0;
            dp_addr_q  <= 8'h00;
        end else begin
            dp_valid_q <= ahb_take;
            if (ahb_take) begin
                dp_write_q <= hwrite;
                dp_addr_q  <= haddr[7:0];
            end
        end
    end

    // Control word: bit 0 lets the pin ports write the array
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= hcp_pkg::CTRL_RESET;
        end else if (ahb_wr && dp_addr_q == hcp_pkg::OFS_CTRL) begin
            ctrl_q <= {31'h0, hwdata[hcp_pkg::CTRL_PIN_EN]};
        end
    end

    hcp_pkg::hcp_rd_state_t rd_state_q;
    logic [31:0] status_w;
    assign status_w = {25'h0, (rd_state_q == hcp_pkg::RD_DRIVE), port_sel, 1'b0, template_code};

    // Zero wait states; read data is a mux of flops, so a read just after a write sees it
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = (dp_addr_q == hcp_pkg::OFS_CTRL)   ? ctrl_q   :
                       (dp_addr_q == hcp_pkg::OFS_STATUS) ? status_w :
                       dp_is_reg ? {24'h0, reg_read(dp_idx)} : 32'h0;

    // ********************************************************
    // Serial port, shift clock domain
    // ********************************************************
    logic [4:0] ser_addr;
    logic [7:0] ser_data;
    logic       ser_rd_tgl;
    logic       ser_wr_tgl;
    logic [7:0] ser_ret_q;
    logic [1:0] tgl_s;
    logic [1:0] tgl_prev_q;

    // Deselect or leaving serial mode ends the frame at once, even with the clock stopped
    wire frame_rst = chip_sel_n | ~mode_sel_mid;

    hcp_serial u_serial (
        .shift_clk       (shift_clk),
        .hresetn         (hresetn),
        .frame_rst       (frame_rst),
        .serial_in       (template_sel_lsb),
        .out_edge_select (out_edge_select),
        .ret_data        (ser_ret_q),
        .ser_addr_q      (ser_addr),
        .ser_data_q      (ser_data),
        .rd_tgl_q        (ser_rd_tgl),
        .wr_tgl_q        (ser_wr_tgl),
        .serial_out      (serial_out),
        .serial_out_oe   (serial_out_oe)
    );

    hcp_sync #(.WIDTH(2), .RST_VAL(2'b00)) u_tgl_sync (
        .clk   (hclk),
        .rst_n (hresetn),
        .d     ({ser_rd_tgl, ser_wr_tgl}),
        .q     (tgl_s)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tgl_prev_q <= 2'b00;
        end else begin
            tgl_prev_q <= tgl_s;
        end
    end

    wire ser_rd_req = tgl_s[1] ^ tgl_prev_q[1];
    wire ser_wr_req = (tgl_s[0] ^ tgl_prev_q[0]) & pin_en;

    // Return word holds still until the next request; the host pauses to let it settle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ser_ret_q <= 8'h00;
        end else if (ser_rd_req) begin
            ser_ret_q <= reg_read(ser_addr);                            // [R16]
        end
    end

    // ********************************************************
    // Parallel port
    // ********************************************************
    logic [4:0] addr_q;

    wire [4:0] eff_addr = (mux_s | nm_ds_mode) ? addr_q : addr_s;
    wire       stb_wr   = par_mode & stb_style & cs_on & ds_rise;                  // [R10]
    wire       ds_wr    = par_mode & ~stb_style & cs_on & ds_rise & ~rw_sel;       // [R9] [R11]
    wire       par_wr   = (stb_wr | ds_wr) & pin_en;
    wire       stb_rd   = par_mode & stb_style & cs_on & rd_fall;                  // [R8]
    wire       ds_rd    = par_mode & ~stb_style & cs_on & ds_fall & rw_sel;        // [R9]
    wire [4:0] rd_addr  = nm_ds_mode ? addr_s : eff_addr;
    wire       rd_end   = ~par_mode | ~cs_on | (stb_style ? rd_rise : ds_rise);    // [R12]

    // Address latch; only bus lines 4:0 are taken in multiplexed modes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_q <= 5'h00;
        end else if (par_mode && mux_s && as_fall) begin
            addr_q <= bus_s[4:0];                                       // [R4] [R5] [R7]
        end else if (nm_ds_mode && ds_fall) begin
            addr_q <= addr_s;                                           // [R13]
        end
    end

    // Read drive: starts on the read strobe edge, ends on its release
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_state_q <= hcp_pkg::RD_IDLE;
            bus_out    <= 8'h00;
        end else begin
            case (rd_state_q)
                hcp_pkg::RD_IDLE: begin
                    if (stb_rd || ds_rd) begin
                        rd_state_q <= hcp_pkg::RD_DRIVE;
                        bus_out    <= reg_read(rd_addr);                // [R12]
                    end
                end
                hcp_pkg::RD_DRIVE: begin
                    if (rd_end) begin
                        rd_state_q <= hcp_pkg::RD_IDLE;
                    end
                end
                default: rd_state_q <= hcp_pkg::RD_IDLE;
            endcase
        end
    end

    assign bus_oe = (rd_state_q == hcp_pkg::RD_DRIVE);

    // ********************************************************
    // Array writes; pin ports win over the bus on a same-cycle clash
    // ********************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < hcp_pkg::REG_LOCS; i++) begin
                regs_q[i] <= hcp_pkg::REG_RESET;
            end
        end else begin
            if (ahb_wr && dp_is_reg && loc_used(dp_idx)) begin
                regs_q[dp_idx] <= hwdata[7:0];                          // [R16]
            end
            if (ser_wr_req && loc_used(ser_addr)) begin
                regs_q[ser_addr] <= ser_data;                           // [R16]
            end
            if (par_wr && loc_used(eff_addr)) begin
                regs_q[eff_addr] <= bus_s;                              // [R10] [R11]
            end
        end
    end

endmodule // host_control_port

// *** hcp_pkg.sv ***
package hcp_pkg;

    // ********************************************************
    // Register array shape
    // ********************************************************
    localparam int unsigned ADDR_W     = 5;
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned REG_LOCS   = 32;
    localparam logic [4:0]  LAST_USED  = 5'h17;      // Locations above this read zero
    localparam logic [7:0]  REG_RESET  = 8'h00;

    // ********************************************************
    // Bus map, byte addresses
    // ********************************************************
    localparam logic [7:0]  OFS_REG_LAST = 8'h7c;    // Location i sits at 4*i
    localparam logic [7:0]  OFS_CTRL     = 8'h80;
    localparam logic [7:0]  OFS_STATUS   = 8'h84;
    localparam int unsigned CTRL_PIN_EN  = 0;
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0001;
    localparam int unsigned ST_TMPL_LSB  = 0;
    localparam int unsigned ST_PORT_LSB  = 4;
    localparam int unsigned ST_RD_BIT    = 6;
    localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;

    // ********************************************************
    // Pin modes
    // ********************************************************
    localparam logic [2:0]  MODE_NM_DS   = 3'h4;     // Separate bus, data strobe
    localparam logic [2:0]  MODE_M_DS    = 3'h5;     // Separate bus, read/write strobes
    localparam logic [2:0]  MODE_NM_STB  = 3'h6;     // Multiplexed bus, data strobe
    localparam logic [2:0]  MODE_M_STB   = 3'h7;     // Multiplexed bus, read/write strobes

    typedef enum logic [1:0] {
        PORT_HW     = 2'b00,
        PORT_SERIAL = 2'b01,
        PORT_PAR    = 2'b10
    } hcp_port_t;

    typedef enum logic [0:0] {
        RD_IDLE  = 1'b0,
        RD_DRIVE = 1'b1
    } hcp_rd_state_t;

    // ********************************************************
    // Pin synchroniser layout and serial frame
    // ********************************************************
    localparam int unsigned PIN_W        = 21;
    localparam logic [20:0] PIN_RESET    = 21'h1e000; // Chip select and strobes idle high
    localparam logic [3:0]  STB_RESET    = 4'hf;
    localparam logic [4:0]  SER_CMD_LAST = 5'h07;     // Count before the eighth rising edge
    localparam logic [4:0]  SER_DAT_LAST = 5'h0f;
    localparam logic [4:0]  SER_FRAME    = 5'h10;
    localparam int unsigned SER_RW_BIT   = 7;

endpackage

// *** hcp_sync.sv ***
`timescale 1ns/1ns
module hcp_sync #(
    parameter int unsigned   WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_q;

    // Two stages; only the second stage is visible outside
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule // hcp_sync

// *** hcp_serial.sv ***
`timescale 1ns/1ns
module hcp_serial (
    input  wire logic       shift_clk,
    input  wire logic       hresetn,
    input  wire logic       frame_rst,
    input  wire logic       serial_in,
    input  wire logic       out_edge_select,
    input  wire logic [7:0] ret_data,
    output logic      [4:0] ser_addr_q,
    output logic      [7:0] ser_data_q,
    output logic            rd_tgl_q,
    output logic            wr_tgl_q,
    output logic            serial_out,
    output logic            serial_out_oe
);

    logic [4:0] cnt_q;
    logic [6:0] sh_q;
    logic       is_read_q;
    logic       pos_out_q;
    logic       neg_out_q;
    logic       edge_sel;
    wire  [7:0] byte_in  = {sh_q, serial_in};
    wire        in_data  = cnt_q[3] & ~cnt_q[4];
    wire  [2:0] bit_idx  = ~cnt_q[2:0];

    // ********************************************************
    // Frame counter and input shifter, cleared while deselected
    // ********************************************************
    always_ff @(posedge shift_clk or posedge frame_rst) begin
        if (frame_rst) begin
            cnt_q     <= 5'h00;
            sh_q      <= 7'h00;
            is_read_q <= 1'b0;
        end else begin
            sh_q <= byte_in[6:0];                                      // [R3]
            if (cnt_q != hcp_pkg::SER_FRAME) begin
                cnt_q <= cnt_q + 5'h01;
            end
            if (cnt_q == hcp_pkg::SER_CMD_LAST) begin
                is_read_q <= byte_in[hcp_pkg::SER_RW_BIT];
            end
        end
    end

    // Handshake words survive the frame so the other domain sees them stable
    always_ff @(posedge shift_clk or negedge hresetn) begin
        if (!hresetn) begin
            ser_addr_q <= 5'h00;
            ser_data_q <= 8'h00;
            rd_tgl_q   <= 1'b0;
            wr_tgl_q   <= 1'b0;
        end else if (cnt_q == hcp_pkg::SER_CMD_LAST) begin
            ser_addr_q <= byte_in[4:0];
            if (byte_in[hcp_pkg::SER_RW_BIT]) begin
                rd_tgl_q <= ~rd_tgl_q;
            end
        end else if (cnt_q == hcp_pkg::SER_DAT_LAST && !is_read_q) begin
            ser_data_q <= byte_in;
            wr_tgl_q   <= ~wr_tgl_q;
        end
    end

    // Edge choice is a static strap, still passed through two stages
    hcp_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_edge_sync (
        .clk   (shift_clk),
        .rst_n (hresetn),
        .d     (out_edge_select),
        .q     (edge_sel)
    );

    // ********************************************************
    // Output launch on either edge; the pin selects which copy
    // ********************************************************
    always_ff @(posedge shift_clk or posedge frame_rst) begin
        if (frame_rst) begin
            pos_out_q <= 1'b0;
        end else if (in_data) begin
            pos_out_q <= ret_data[bit_idx];                            // [R2]
        end
    end

    always_ff @(negedge shift_clk or posedge frame_rst) begin
        if (frame_rst) begin
            neg_out_q <= 1'b0;
        end else if (in_data) begin
            neg_out_q <= ret_data[bit_idx];                            // [R2]
        end
    end

    assign serial_out    = edge_sel ? neg_out_q : pos_out_q;            // [R2]
    assign serial_out_oe = is_read_q & (cnt_q[3] | cnt_q[4]);

endmodule // hcp_serial

// *** hcp_assertions.sv ***
`timescale 1ns/1ns
// ********************************************************
// Pin and bus side checker
// ********************************************************
module hcp_assertions (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        mode_sel_hi,
    input wire logic        mode_sel_mid,
    input wire logic        mode_sel_0,
    input wire logic        chip_sel_n,
    input wire logic        template_sel_msb,
    input wire logic        template_sel_mid,
    input wire logic        template_sel_lsb,
    input wire logic        bus_oe,
    input wire logic        serial_out_oe,
    input wire logic [2:0]  template_code
);
    wire rd_req = hsel && hready && htrans == 2'h2 && !hwrite;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Five cycles cover the two sync flops plus the code register
    tmpl_follow_a: assert property (
        (!mode_sel_hi && !mode_sel_mid && $stable({template_sel_msb, template_sel_mid, template_sel_lsb}))[*5]
        |-> template_code == {template_sel_msb, template_sel_mid, template_sel_lsb}) else $error("template lags pins");
    tmpl_hold_a: assert property ((mode_sel_hi || mode_sel_mid)[*4] |=> $stable(template_code))
        else $error("template moved off hw mode");
    park_a: assert property ((!mode_sel_hi || mode_sel_mid)[*4] |-> !bus_oe)
        else $error("bus driven off parallel");
    cs_idle_a: assert property (chip_sel_n[*5] |-> !bus_oe) else $error("bus driven while deselected");
    // A drive must trace back to a read strobe seen two cycles earlier
    oe_cause_a: assert property ($rose(bus_oe) |-> $past(!chip_sel_n && (mode_sel_0 ? !template_sel_mid
        : (template_sel_mid && !template_sel_lsb)), 2)) else $error("drive without read strobe");
    oe_drop_a: assert property ((!mode_sel_0 && template_sel_lsb)[*5] |-> !bus_oe)
        else $error("drive outlives data strobe");
    rd_hole_a: assert property (rd_req && haddr[7:5] == 3'h3
        |=> hrdata == 32'h0) else $error("unused location not zero");
    rd_narrow_a: assert property (rd_req && !haddr[7]
        |=> hrdata[31:8] == 24'h0) else $error("upper read bits set");
    ser_quiet_a: assert property (chip_sel_n |-> !serial_out_oe) else $error("serial out driven idle");
endmodule // hcp_assertions

// *** hcp_host_model.sv ***
`timescale 1ns/1ns
// ********************************************************
// Host processor on the pin side
// ********************************************************
module hcp_host_model (
    output logic       cs_n,
    output logic       tmsb,
    output logic       tmid,
    output logic       tlsb,
    output logic [4:0] addr,
    output logic [7:0] bus_drv,
    input  wire logic [7:0] bus_wire,
    input  wire logic       ser_out
);
    // Idle: deselected, strobes high, latch enable held high
    initial {cs_n, tmsb, tmid, tlsb, addr, bus_drv} = 17'h1e000;
    // Hardware mode template pins
    task automatic hw(input logic [2:0] c);
        {tmsb, tmid, tlsb} = c;
    endtask
    // One parallel byte access; junk on lines 7:5 during the address phase
    task automatic par(input logic mux, stb, wr, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
        {tmsb, tmid, tlsb} = 3'h7;
        #20 cs_n = 1'b0;
        addr = a;
        bus_drv = {3'h5, a};
        #30 if (mux) tmsb = 1'b0;
        #30 bus_drv = wr ? d : ~bus_drv; // Released bus shows the inverse
        if (!stb) tmid = !wr;
        #20 if (stb && !wr) tmid = 1'b0;
        else tlsb = 1'b0;
        #80 q = bus_wire;
        tlsb = 1'b1;
        if (stb) tmid = 1'b1;
        #30 {tmsb, tmid, tlsb} = 3'h7;
        bus_drv = ~bus_drv;
        cs_n = 1'b1;
        #60;
    endtask
    // Serial frame: command then data, MSB first; clock rests low outside the frame
    task automatic ser(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
        logic [15:0] f = {!wr, 2'h0, a, d};
        q = 8'h00;
        tmsb = 1'b0;
        #20 cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            tlsb = f[i];
            #6 tmsb = 1'b1;
            #3 if (i < 8) q[i] = ser_out; // Mid-high sampling suits both launch edges
            #3 tmsb = 1'b0;
            if (i == 8) #120; // Turnaround before the first data bit
        end
        tlsb = ~f[0];
        #20 cs_n = 1'b1;
        #60;
    endtask
endmodule // hcp_host_model

// *** host_control_port_tb_top.sv ***
`timescale 1ns/1ns
module host_control_port_tb_top;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, out_edge_select = 0;
    logic        mode_sel_hi = 0, mode_sel_mid = 0, mode_sel_1 = 0, mode_sel_0 = 0;
    logic [31:0] haddr = 0, hwdata = 0, q;
    logic [1:0]  htrans = 0;
    logic [7:0]  d, b;
    logic [4:0]  a;
    wire  logic  hreadyout, hresp, bus_oe, serial_out, serial_out_oe, cs_n, tmsb, tmid, tlsb;
    wire  logic [31:0] hrdata;
    wire  logic [7:0]  bus_out, bus_drv;
    wire  logic [4:0]  addr;
    wire  logic [2:0]  template_code;
    wire  logic [7:0]  bus_wire = bus_oe ? bus_out : bus_drv;
    int          error_cnt = 0, checks_done = 0, seed = 42739;
    // Clock
    always #5 hclk = ~hclk;
    host_control_port i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .mode_sel_hi, .mode_sel_mid, .mode_sel_1, .mode_sel_0,
        .chip_sel_n(cs_n), .template_sel_msb(tmsb), .template_sel_mid(tmid), .template_sel_lsb(tlsb),
        .shift_clk(tmsb), .out_edge_select, .addr_pins(addr), .bus_in(bus_wire), .bus_out, .bus_oe,
        .serial_out, .serial_out_oe, .template_code);
    hcp_host_model i_host (.cs_n, .tmsb, .tmid, .tlsb, .addr, .bus_drv, .bus_wire, .ser_out(serial_out));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Bounded wait for the slave's ready
    task automatic rdy();
        int n;
        @(posedge hclk);
        for (n = 0; hreadyout !== 1'b1 && n < 50; n++) @(posedge hclk);
        if (n == 50) begin
            error_cnt++;
            tally_and_finish();
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, ad};
        hwrite <= wr;
        rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        rdy();
        rd = hrdata;
    endtask
    task automatic mode(input logic [3:0] m);
        @(posedge hclk);
        {mode_sel_hi, mode_sel_mid, mode_sel_1, mode_sel_0} <= m;
        repeat (5) @(posedge hclk);
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(0, 8'h80, 0, q);
        chk("ctrl reset", q, 32'h1);
        for (int i = 0; i < 32; i++) begin
            ahb(0, i * 4, 0, q);
            chk("loc reset", q, 32'h0);
            d = $random(seed);
            ahb(1, i * 4, {4{d}}, q);
            ahb(0, i * 4, 0, q);
            chk("loc rdback", q, i < 24 ? d : 32'h0);
        end
        $display("test registers done");
        for (int c = 0; c < 8; c++) begin
            i_host.hw(c[2:0]);
            repeat (6) @(posedge hclk);
            chk("template", template_code, c);
        end
        $display("test template done");
        mode(4'b0100);
        for (int e = 0; e < 2; e++) begin
            out_edge_select <= e[0];
            a = {$random(seed)} % 24;
            d = $random(seed);
            #7 i_host.ser(1, a, d, b);
            #100 ahb(0, a * 4, 0, q);
            chk("ser write", q, d);
            d = $random(seed);
            ahb(1, a * 4, d, q);
            i_host.ser(0, a, 8'h00, b);
            chk("ser read", b, d);
        end
        chk("template held", template_code, 3'h7);
        $display("test serial done");
        for (int m = 0; m < 4; m++) begin
            mode({2'b10, m[1:0]});
            a = {$random(seed)} % 24;
            d = $random(seed);
            i_host.par(m[1], m[0], 1, a, d, b);
            ahb(0, a * 4, 0, q);
            chk("par write", q, d);
            d = $random(seed);
            ahb(1, a * 4, d, q);
            i_host.par(m[1], m[0], 0, a, 8'h00, b);
            chk("par read", b, d);
        end
        $display("test parallel done");
        tally_and_finish();
    end
endmodule // host_control_port_tb_top
bind host_control_port hcp_assertions i_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
    .mode_sel_hi, .mode_sel_mid, .mode_sel_0, .chip_sel_n, .template_sel_msb, .template_sel_mid, .template_sel_lsb,
    .bus_oe, .serial_out_oe, .template_code);
